// ### shared/fieldbus_io_pkg.sv
// Purpose: shared constants and carriers for the fieldbus process-image core
// Assumes: one 50 MHz clock, byte-wide parameter and record ports
// Notes:   record byte counts and presets live here so core and store agree
package fieldbus_io_pkg;

  // ==========================================================================
  // Clock and time
  localparam int unsigned CLOCK_HZ       = 50_000_000;
  localparam int unsigned WDOG_TIMEOUT_MS = 100;
  localparam int unsigned WDOG_CYCLES    = (CLOCK_HZ / 1000) * WDOG_TIMEOUT_MS;

  // ==========================================================================
  // Parameter telegram layout
  localparam logic [7:0] PRM_DP_FIRST      = 8'h01;
  localparam logic [7:0] PRM_DP_LAST       = 8'h07;
  localparam logic [7:0] PRM_DPV1_FIRST    = 8'h08;
  localparam logic [7:0] PRM_DPV1_LAST     = 8'h0a;
  localparam logic [7:0] PRM_FALLBACK_MODE = 8'h0b;
  localparam logic [7:0] PRM_CHAN_LEVELS   = 8'h0c;
  localparam logic [7:0] PRM_LAST          = 8'h0c;
  // Bits within DP/V1 byte 8: alarm enable, sync/freeze enables, watchdog enable
  localparam int unsigned DPV1_ALARM_BIT   = 0;
  localparam int unsigned DPV1_SYNC_BIT    = 1;
  localparam int unsigned DPV1_FREEZE_BIT  = 2;
  localparam int unsigned DPV1_WDOG_BIT    = 3;

  // ==========================================================================
  // Reset values
  localparam logic [7:0] FALLBACK_MODE_RST = 8'h00;
  localparam logic [7:0] CHAN_LEVELS_RST   = 8'h00;
  localparam logic       ALARM_EN_RST      = 1'b1;

  // ==========================================================================
  // Status word fields
  localparam int unsigned ST_OUT_SHORT   = 0;
  localparam int unsigned ST_OUT_OVLD    = 1;
  localparam int unsigned ST_ACT_SHORT   = 2;
  localparam int unsigned ST_ACT_UNDERV  = 3;
  localparam int unsigned ST_MOD_OVLD    = 4;
  localparam int unsigned ST_MOD_UNDERV  = 5;
  localparam int unsigned ST_USED_BITS   = 6;

  // ==========================================================================
  // Record store: one flat byte space, records back to back
  localparam int unsigned IM0_BYTES  = 48;
  localparam int unsigned IM1_BYTES  = 54;
  localparam int unsigned IM2_BYTES  = 54;
  localparam int unsigned IM3_BYTES  = 54;
  localparam int unsigned IM_RW_BASE = IM0_BYTES;
  localparam int unsigned IM_BYTES   = IM0_BYTES + IM1_BYTES + IM2_BYTES + IM3_BYTES;
  localparam int unsigned IM2_RSV_LO = IM_RW_BASE + IM1_BYTES + 16;
  localparam int unsigned IM2_RSV_HI = IM2_RSV_LO + 37;
  localparam logic [7:0]  IM_SPACE   = 8'h20;
  // Revision counter position inside the fixed record
  localparam int unsigned IM0_REVCNT = 44;

  typedef enum logic [1:0] {
    FB_ALL_LOW  = 2'b00,
    FB_ALL_HIGH = 2'b01,
    FB_HOLD     = 2'b10,
    FB_CHANNEL  = 2'b11
  } fallback_type;

  // Diagnostic conditions from the supervisors
  typedef struct packed {
    logic over_temp;
    logic sens_surge;
    logic sens_ovld;
    logic act_surge;
    logic act_underv;
    logic act_short;
    logic out_short;
    logic out_ovld;
  } diag_type;

  // Parameter byte write strobe with data
  typedef struct packed {
    logic       valid;
    logic [7:0] index;
    logic [7:0] data;
  } prm_write_type;

  // Record access
  typedef struct packed {
    logic       valid;
    logic       write;
    logic [7:0] addr;
    logic [7:0] data;
  } rec_req_type;

endpackage

// ### src/fieldbus_io_wdog.sv
// Purpose: process-data watchdog counter
// Assumes: kick is high for one cycle per process-data write
// Notes:   expiry is sticky until the next kick or disarm
`timescale 1ns/1ps
module fieldbus_io_wdog #(
  parameter int unsigned CYCLES = fieldbus_io_pkg::WDOG_CYCLES
) (
  input  wire logic i_clock,
  input  wire logic i_rst,
  input  wire logic i_enable,
  input  wire logic i_kick,
  output logic      o_expired
);
  import fieldbus_io_pkg::*;

  typedef struct packed {
    logic        armed;
    logic        expired;
    logic [31:0] count;
  } wdog_state_type;

  wdog_state_type s_q;
  wdog_state_type s_d;

  // ==========================================================================
  // Counter: armed by first write, restarted by each later one
  always_comb begin
    s_d = s_q;
    if (!i_enable) begin
      s_d = '0;
    end else if (i_kick) begin
      s_d.armed   = 1'b1;
      s_d.expired = 1'b0;
      s_d.count   = '0;
    end else if (s_q.armed && !s_q.expired) begin
      if (s_q.count >= 32'(CYCLES - 1)) begin
        s_d.expired = 1'b1;
      end else begin
        s_d.count = s_q.count + 32'h0000_0001;
      end
    end
  end

  always_ff @(posedge i_clock or posedge i_rst) begin
    if (i_rst) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign o_expired = s_q.expired;

  // ==========================================================================
  // Checks
  a_wdog_kick_clears: assert property (@(posedge i_clock) disable iff (i_rst)
    (i_enable && i_kick) |=> !o_expired) else $error("watchdog not cleared by write");

  a_wdog_no_early: assert property (@(posedge i_clock) disable iff (i_rst)
    (i_enable && i_kick) |=> !o_expired [*2]) else $error("watchdog expired too soon");
endmodule

// ### src/fieldbus_io_records.sv
// Purpose: identification and maintenance record store
// Assumes: one byte per request; reads answer one cycle later
// Notes:   writes to the fixed record are ignored
`timescale 1ns/1ps
module fieldbus_io_records #(
  parameter logic [15:0] MAKER_CODE = 16'h1234  // Arbitrary value
) (
  input  wire logic                        i_clock,
  input  wire logic                        i_rst,
  input  wire fieldbus_io_pkg::rec_req_type i_req,
  output logic [7:0]                       o_rdata,
  output logic                             o_rvalid
);
  import fieldbus_io_pkg::*;

  typedef struct packed {
    logic [IM_BYTES-IM_RW_BASE-1:0][7:0] rw;
    logic [7:0]                          rdata;
    logic                                rvalid;
  } rec_state_type;

  rec_state_type s_q;
  rec_state_type s_d;
  logic [IM0_BYTES-1:0][7:0] fixed_rec;

  // ==========================================================================
  // fixed record, revision counter zero
  always_comb begin
    fixed_rec    = '0;
    fixed_rec[0] = MAKER_CODE[15:8];
    fixed_rec[1] = MAKER_CODE[7:0];
    fixed_rec[IM0_REVCNT]   = 8'h00;
    fixed_rec[IM0_REVCNT+1] = 8'h00;
  end

  // ==========================================================================
  // writable records; reads mux fixed or writable
  always_comb begin
    s_d        = s_q;
    s_d.rvalid = i_req.valid && !i_req.write;
    if (i_req.valid && !i_req.write) begin
      if (i_req.addr < 8'(IM_RW_BASE)) begin
        s_d.rdata = fixed_rec[i_req.addr];
      end else if (i_req.addr < 8'(IM_BYTES)) begin
        s_d.rdata = s_q.rw[i_req.addr - 8'(IM_RW_BASE)];
      end else begin
        s_d.rdata = 8'h00;
      end
    end
    if (i_req.valid && i_req.write && i_req.addr >= 8'(IM_RW_BASE) && i_req.addr < 8'(IM_BYTES)) begin
      s_d.rw[i_req.addr - 8'(IM_RW_BASE)] = i_req.data;
    end
  end

  // Presets: text fields spaces, reserved area zero
  always_ff @(posedge i_clock or posedge i_rst) begin
    if (i_rst) begin
      for (int i = 0; i < IM_BYTES - IM_RW_BASE; i++) begin
        s_q.rw[i] <= ((i + IM_RW_BASE) >= IM2_RSV_LO && (i + IM_RW_BASE) <= IM2_RSV_HI) ? 8'h00 : IM_SPACE;
      end
      s_q.rdata  <= 8'h00;
      s_q.rvalid <= 1'b0;
    end else begin
      s_q <= s_d;
    end
  end

  assign o_rdata  = s_q.rdata;
  assign o_rvalid = s_q.rvalid;

  a_rec_read_ack: assert property (@(posedge i_clock) disable iff (i_rst)
    (i_req.valid && !i_req.write) |=> o_rvalid) else $error("record read not answered");
endmodule

// ### src/fieldbus_io_process_image.sv
// Purpose: process-data core of a fieldbus slave, 8 inputs and 4 outputs
// Assumes: protocol engine delivers decoded strobes synchronous to i_clock
// Notes:   alarm strobes last one cycle, raised at diagnostic edges
`timescale 1ns/1ps

// Notes on behaviour
// - Input n+1 reported in input bit n
// - Output bits 3..0 drive outputs 1..4
// - Status word 32 bits, top reserved zero
// - Status bits 0..5 flag supply/output faults
// - Byte 11 bits 1:0 pick fallback mode
// - Byte 12 bits 0..3 per-channel fallback
// - Telegram layout: DP, DP/V1, module bytes
// - Fixed identification record, counter zero
// - Writable records preset to spaces/zero
// - Sync/freeze only when parameter-enabled
// - Sync latches outputs until next sync
// - Freeze latches inputs until next freeze
// - Alarms enabled by default, parameter disables
// - Incoming alarm at first set, outgoing when all clear
// - Group fault lit while any diagnostic
// - Eight diagnostic conditions generated
// - Watchdog starts/restarts with process writes
// - Process reads never restart watchdog
// - Timeout forces fallback, lights bus fault
// - Bus failure forces parameterized fallback
module fieldbus_io_process_image #(
  parameter int unsigned   WDOG_CYCLES = fieldbus_io_pkg::WDOG_CYCLES,
  parameter logic [15:0]   MAKER_CODE  = 16'h1234  // Arbitrary value
) (
  input  wire logic                           i_clock,
  input  wire logic                           i_rst,
  input  wire logic [7:0]                     i_digital_input_pin,
  output logic      [3:0]                     o_digital_output_pin,
  input  wire logic                           i_out_write,
  input  wire logic [7:0]                     i_out_data,
  input  wire logic                           i_in_read,
  output logic      [7:0]                     o_input_image_byte,
  output logic      [7:0]                     o_output_image_byte,
  input  wire fieldbus_io_pkg::prm_write_type i_prm,
  input  wire logic                           i_sync,
  input  wire logic                           i_unsync,
  input  wire logic                           i_freeze,
  input  wire logic                           i_unfreeze,
  input  wire logic                           i_bus_ok,
  input  wire logic                           i_data_valid,
  input  wire fieldbus_io_pkg::diag_type      i_diag,
  input  wire logic                           i_mod_ovld,
  input  wire logic                           i_mod_underv,
  output logic      [31:0]                    o_module_status_word,
  output logic                                o_alarm_incoming,
  output logic                                o_alarm_outgoing,
  output logic                                o_group_fault_indicator,
  output logic                                o_bus_fault_indicator,
  input  wire fieldbus_io_pkg::rec_req_type   i_rec,
  output logic      [7:0]                     o_rec_rdata,
  output logic                                o_rec_rvalid
);
  import fieldbus_io_pkg::*;

  typedef struct packed {
    logic [7:0] fallback_behaviour_param;
    logic [7:0] channel_fallback_levels_param;
    logic       alarm_en;
    logic       sync_en;
    logic       freeze_en;
    logic       wdog_en;
    logic       sync_mode;
    logic       freeze_mode;
    logic [7:0] output_image_byte;
    logic [7:0] input_image_byte;
    logic [3:0] outputs;
    logic [3:0] applied;
    diag_type   diag;
    logic       alarm_in;
    logic       alarm_out;
    logic [31:0] status;
  } core_state_type;

  core_state_type s_q;
  core_state_type s_d;
  logic           wdog_expired;
  logic           fault;
  logic [3:0]     fallback_val;
  fallback_type   fb_mode;

  // ==========================================================================
  // Watchdog, kicked by writes only
  // reads not wired to the kick
  fieldbus_io_wdog #(
    .CYCLES (WDOG_CYCLES)
  ) u_wdog (
    .i_clock   (i_clock),
    .i_rst     (i_rst),
    .i_enable  (s_q.wdog_en),
    .i_kick    (i_out_write),
    .o_expired (wdog_expired)
  );

  // ==========================================================================
  // Record store
  fieldbus_io_records #(
    .MAKER_CODE (MAKER_CODE)
  ) u_records (
    .i_clock  (i_clock),
    .i_rst    (i_rst),
    .i_req    (i_rec),
    .o_rdata  (o_rec_rdata),
    .o_rvalid (o_rec_rvalid)
  );

  // ==========================================================================
  // Fallback value select
  // mode from byte 11
  assign fb_mode = fallback_type'(s_q.fallback_behaviour_param[1:0]);
  // Fault is combinational: pins fall back in the cycle the bus is lost
  // fault also covers lost bus and invalid data
  assign fault   = wdog_expired || !i_bus_ok || !i_data_valid;

  always_comb begin
    unique case (fb_mode)
      FB_ALL_LOW:  fallback_val = 4'h0;
      FB_ALL_HIGH: fallback_val = 4'hf;
      FB_HOLD:     fallback_val = s_q.applied;
      FB_CHANNEL:  fallback_val = s_q.channel_fallback_levels_param[3:0];
    endcase
  end

  // ==========================================================================
  // Next state
  always_comb begin
    s_d = s_q;
    // module bytes at 11 and 12, DP/V1 flags at 8
    if (i_prm.valid) begin
      if (i_prm.index == PRM_FALLBACK_MODE) begin
        s_d.fallback_behaviour_param = i_prm.data;
      end
      if (i_prm.index == PRM_CHAN_LEVELS) begin
        s_d.channel_fallback_levels_param = i_prm.data;
      end
      if (i_prm.index == PRM_DPV1_FIRST) begin
        s_d.alarm_en  = i_prm.data[DPV1_ALARM_BIT];
        s_d.sync_en   = i_prm.data[DPV1_SYNC_BIT];
        s_d.freeze_en = i_prm.data[DPV1_FREEZE_BIT];
        s_d.wdog_en   = i_prm.data[DPV1_WDOG_BIT];
      end
    end
    // Sync and freeze mode entry and exit
    if (i_sync && s_q.sync_en) begin
      s_d.sync_mode = 1'b1;
    end else if (i_unsync) begin
      s_d.sync_mode = 1'b0;
    end
    if (i_freeze && s_q.freeze_en) begin
      s_d.freeze_mode = 1'b1;
    end else if (i_unfreeze) begin
      s_d.freeze_mode = 1'b0;
    end
    // Dropping an enable also leaves its mode, so no stale latch remains
    if (!s_d.sync_en) begin
      s_d.sync_mode = 1'b0;
    end
    if (!s_d.freeze_en) begin
      s_d.freeze_mode = 1'b0;
    end
    // Output image written by master
    if (i_out_write) begin
      s_d.output_image_byte = i_out_data;
    end
    // freeze captures inputs; else track live
    if (!s_q.freeze_mode || (i_freeze && s_q.freeze_en)) begin
      s_d.input_image_byte = i_digital_input_pin;
    end
    // sync transfers outputs; else follow image
    if (!s_q.sync_mode || (i_sync && s_q.sync_en)) begin
      s_d.outputs = s_q.output_image_byte[3:0];
    end
    // Remember last level actually driven while healthy
    // Take the updated level, so a fault just after an update holds it
    if (!fault) begin
      s_d.applied = s_d.outputs;
    end
    s_d.diag      = i_diag;
    s_d.alarm_in  = s_q.alarm_en && (s_q.diag == '0) && (i_diag != '0);
    s_d.alarm_out = s_q.alarm_en && (s_q.diag != '0) && (i_diag == '0);
    s_d.status                = '0;
    s_d.status[ST_OUT_SHORT]  = i_diag.out_short;
    s_d.status[ST_OUT_OVLD]   = i_diag.out_ovld;
    s_d.status[ST_ACT_SHORT]  = i_diag.act_short;
    s_d.status[ST_ACT_UNDERV] = i_diag.act_underv;
    s_d.status[ST_MOD_OVLD]   = i_mod_ovld;
    s_d.status[ST_MOD_UNDERV] = i_mod_underv;
  end

  always_ff @(posedge i_clock or posedge i_rst) begin
    if (i_rst) begin
      s_q                               <= '0;
      s_q.fallback_behaviour_param      <= FALLBACK_MODE_RST;
      s_q.channel_fallback_levels_param <= CHAN_LEVELS_RST;
      s_q.alarm_en                      <= ALARM_EN_RST;
    end else begin
      s_q <= s_d;
    end
  end

  // ==========================================================================
  // Outputs
  // fallback during fault
  assign o_digital_output_pin    = fault ? fallback_val : s_q.outputs;
  assign o_input_image_byte      = s_q.input_image_byte;
  assign o_output_image_byte     = s_q.output_image_byte;
  assign o_module_status_word    = s_q.status;
  assign o_alarm_incoming        = s_q.alarm_in;
  assign o_alarm_outgoing        = s_q.alarm_out;
  assign o_group_fault_indicator = (s_q.diag != '0);
  // bus fault at timeout or lost bus
  assign o_bus_fault_indicator   = fault;

  // ==========================================================================
  // Checks
  // mapping and status
  a_input_map: assert property (@(posedge i_clock) disable iff (i_rst)
    !s_q.freeze_mode |=> o_input_image_byte == $past(i_digital_input_pin))
    else $error("input map wrong");
  a_out_map: assert property (@(posedge i_clock) disable iff (i_rst)
    (!s_q.sync_mode && !i_sync) |=> s_q.outputs == $past(s_q.output_image_byte[3:0]))
    else $error("output map wrong");
  a_status_rsv: assert property (@(posedge i_clock) disable iff (i_rst)
    o_module_status_word[31:ST_USED_BITS] == '0)
    else $error("reserved status bits set");
  a_status_short: assert property (@(posedge i_clock) disable iff (i_rst)
    i_diag.out_short |=> o_module_status_word[ST_OUT_SHORT])
    else $error("short not flagged");
  a_status_supply: assert property (@(posedge i_clock) disable iff (i_rst)
    i_mod_underv |=> o_module_status_word[ST_MOD_UNDERV])
    else $error("supply undervoltage not flagged");

  a_fault_low: assert property (@(posedge i_clock) disable iff (i_rst)
    (fault && fb_mode == FB_ALL_LOW) |-> o_digital_output_pin == 4'h0)
    else $error("fallback low wrong");
  a_fault_high: assert property (@(posedge i_clock) disable iff (i_rst)
    (fault && fb_mode == FB_ALL_HIGH) |-> o_digital_output_pin == 4'hf)
    else $error("fallback high wrong");
  a_fault_chan: assert property (@(posedge i_clock) disable iff (i_rst)
    (fault && fb_mode == FB_CHANNEL) |-> o_digital_output_pin == s_q.channel_fallback_levels_param[3:0])
    else $error("channel fallback wrong");
  a_hold_last: assert property (@(posedge i_clock) disable iff (i_rst)
    (fault && $past(fault) && fb_mode == FB_HOLD && $past(fb_mode) == FB_HOLD) |-> $stable(o_digital_output_pin))
    else $error("held level moved");

  a_sync_gate: assert property (@(posedge i_clock) disable iff (i_rst)
    !s_q.sync_en |-> !s_q.sync_mode)
    else $error("sync mode while disabled");
  a_sync_hold: assert property (@(posedge i_clock) disable iff (i_rst)
    (s_q.sync_mode && !i_sync && !i_unsync && s_q.sync_en && !i_prm.valid) |=> $stable(s_q.outputs))
    else $error("outputs moved in sync");
  a_freeze_hold: assert property (@(posedge i_clock) disable iff (i_rst)
    (s_q.freeze_mode && !i_freeze && !i_unfreeze && s_q.freeze_en && !i_prm.valid) |=> $stable(o_input_image_byte))
    else $error("inputs moved in freeze");

  a_alarm_gate: assert property (@(posedge i_clock) disable iff (i_rst)
    !s_q.alarm_en |=> !o_alarm_incoming && !o_alarm_outgoing)
    else $error("alarm while disabled");
  a_alarm_in: assert property (@(posedge i_clock) disable iff (i_rst)
    (s_q.alarm_en && s_q.diag == '0 && i_diag != '0) |=> o_alarm_incoming)
    else $error("incoming alarm missing");
  a_alarm_out: assert property (@(posedge i_clock) disable iff (i_rst)
    (s_q.alarm_en && s_q.diag != '0 && i_diag == '0) |=> o_alarm_outgoing)
    else $error("outgoing alarm missing");
  a_group_fault: assert property (@(posedge i_clock) disable iff (i_rst)
    (i_diag != '0) |=> o_group_fault_indicator)
    else $error("group fault not lit");
  a_group_clear: assert property (@(posedge i_clock) disable iff (i_rst)
    (i_diag == '0) |=> !o_group_fault_indicator)
    else $error("group fault stuck");

  a_read_no_kick: assert property (@(posedge i_clock) disable iff (i_rst)
    (wdog_expired && i_in_read && !i_out_write && s_q.wdog_en) |=> wdog_expired)
    else $error("read restarted watchdog");
  a_bus_fault: assert property (@(posedge i_clock) disable iff (i_rst)
    wdog_expired |-> o_bus_fault_indicator)
    else $error("bus fault not shown");
  a_bus_lost: assert property (@(posedge i_clock) disable iff (i_rst)
    (!i_bus_ok || !i_data_valid) |-> o_digital_output_pin == fallback_val)
    else $error("bus loss not falling back");

  // Main scenarios reached
  c_sync: cover property (@(posedge i_clock) i_sync && s_q.sync_en);
  c_freeze: cover property (@(posedge i_clock) i_freeze && s_q.freeze_en);
  c_timeout: cover property (@(posedge i_clock) $rose(wdog_expired));
  c_alarm: cover property (@(posedge i_clock) o_alarm_incoming);
  c_hold: cover property (@(posedge i_clock) fault && fb_mode == FB_HOLD);
endmodule

// ### dv/dp_master_model.sv
// Purpose: behavioural bus master feeding the process-image core
// Assumes: strobes change 1 ns after a rising edge, one cycle wide
// Notes:   the bench calls these tasks through the instance
`timescale 1ns/1ps
module dp_master_model (
  input  wire logic                      i_clock,
  output logic                           o_out_write,
  output logic [7:0]                     o_out_data,
  output fieldbus_io_pkg::prm_write_type o_prm,
  output logic [4:0]                     o_ctl
);
  import fieldbus_io_pkg::*;
  // ==========================================================================
  // Idle levels before the first request
  initial begin
    o_out_write = 1'b0;
    o_out_data  = 8'h00;
    o_prm       = '0;
    o_ctl       = 5'h00;
  end
  // Step just past the next rising edge
  task automatic step();
    @(posedge i_clock);
    #1;
  endtask
  // parameter byte at its telegram index
  task automatic prm(input logic [7:0] idx, input logic [7:0] d);
    step();
    o_prm = '{1'b1, idx, d};
    step();
    o_prm = '{1'b0, ~idx, ~d}; // Released lines show no stale value
  endtask
  // each process write restarts the watchdog
  task automatic wr(input logic [7:0] d);
    step();
    o_out_write = 1'b1;
    o_out_data  = d;
    step();
    o_out_write = 1'b0;
    o_out_data  = ~d;
  endtask
  // Control strobe: 4 read, 3 sync, 2 unsync, 1 freeze, 0 unfreeze
  task automatic cmd(input int k);
    step();
    o_ctl[k] = 1'b1;
    step();
    o_ctl[k] = 1'b0;
  endtask
endmodule

// ### dv/tb_fieldbus_io_process_image.sv
// Purpose: self-checking bench for the process-image core
// Assumes: watchdog shortened to 20 cycles, maker code 16'h5a5a
// Notes:   record reads are compared from a queue of expectations
`timescale 1ns/1ps
module tb_fieldbus_io_process_image;
  import fieldbus_io_pkg::*;
  localparam int unsigned WD = 20;
  logic          clock = 1'b0;
  logic          rst;
  logic [7:0]    pins;
  logic          bus_ok;
  logic          dval;
  logic          movl;
  logic          muv;
  diag_type      diag;
  rec_req_type   rq;
  logic          wr_s, al_in, al_out, sf, bf, rvalid;
  logic [7:0]    wr_d, img_in, img_out, rdata, r, lv;
  logic [3:0]    dout, fb;
  logic [4:0]    ctl;
  logic [31:0]   status;
  prm_write_type prm;
  logic [7:0]    exp_q[$];
  int            err_total = 0;
  int            checks = 0;
  int            n_in = 0;
  int            n_out = 0;
  // ==========================================================================
  // Clock, partner and design
  always #10 clock = ~clock;
  dp_master_model m (.i_clock(clock), .o_out_write(wr_s), .o_out_data(wr_d), .o_prm(prm), .o_ctl(ctl));
  // Maker code value is arbitrary; equal bytes make byte order irrelevant
  fieldbus_io_process_image #(.WDOG_CYCLES(WD), .MAKER_CODE(16'h5a5a)) dut (
    .i_clock(clock), .i_rst(rst), .i_digital_input_pin(pins), .o_digital_output_pin(dout),
    .i_out_write(wr_s), .i_out_data(wr_d), .i_in_read(ctl[4]), .o_input_image_byte(img_in),
    .o_output_image_byte(img_out), .i_prm(prm), .i_sync(ctl[3]), .i_unsync(ctl[2]),
    .i_freeze(ctl[1]), .i_unfreeze(ctl[0]), .i_bus_ok(bus_ok), .i_data_valid(dval),
    .i_diag(diag), .i_mod_ovld(movl), .i_mod_underv(muv), .o_module_status_word(status),
    .o_alarm_incoming(al_in), .o_alarm_outgoing(al_out), .o_group_fault_indicator(sf),
    .o_bus_fault_indicator(bf), .i_rec(rq), .o_rec_rdata(rdata), .o_rec_rvalid(rvalid));
  // ==========================================================================
  // Shared tasks
  task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      err_total++;
      $display("ERROR %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge clock);
    #1;
  endtask
  // One record byte; a read leaves its expected answer in the queue
  task automatic rec(input logic w, input logic [7:0] a, input logic [7:0] d, input logic [7:0] e);
    tick(1);
    rq = '{1'b1, w, a, d};
    if (!w) exp_q.push_back(e);
    tick(1);
    rq = '{1'b0, 1'b0, ~a, ~d};
  endtask
  task automatic report_and_stop();
    $display("checks %0d errors %0d", checks, err_total);
    if (err_total == 0 && checks > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  // ==========================================================================
  // Watcher: answers pair with the oldest note, alarm strobes are counted
  always @(posedge clock) begin
    if (rvalid === 1'b1) check("rec_rdata", rdata, exp_q.pop_front());
    if (al_in === 1'b1) n_in++;
    if (al_out === 1'b1) n_out++;
  end
  // Cut a hang short; the run needs far less than 1 ms
  initial begin
    #1_000_000;
    err_total++;
    report_and_stop();
  end
  // ==========================================================================
  // Main sequence
  initial begin
    void'($urandom(32'hd08b));
    rst = 1'b1;
    pins = 8'($urandom);
    {bus_ok, dval, movl, muv} = 4'b1100;
    diag = '0;
    rq = '0;
    tick(2);
    rst = 1'b0;
    rec(0, 8'd0, 0, 8'h5a);
    rec(0, 8'd45, 0, 8'h00);
    rec(1, 8'd2, 8'hff, 0);
    rec(0, 8'd2, 0, 8'h00);
    rec(0, 8'd48, 0, 8'h20);
    rec(0, 8'(IM2_RSV_LO), 0, 8'h00);
    rec(0, 8'd209, 0, 8'h20);
    r = 8'($urandom);
    rec(1, 8'd48, r, 0);
    rec(0, 8'd48, 0, r);
    rec(0, 8'd210, 0, 8'h00);
    // input n+1 on bit n, walking one then random
    for (int k = 0; k < 9; k++) begin
      pins = (k < 8) ? 8'h01 << k : 8'($urandom);
      tick(2);
      check("in_image", img_in, pins);
    end
    r = 8'($urandom);
    m.wr(r);
    tick(1);
    check("out_image", img_out, r);
    check("out_pins", dout, r[3:0]);
    for (int k = 0; k < 8; k++) begin
      diag = diag_type'(8'h01 << k);
      {movl, muv} = 2'($urandom);
      tick(3);
      check("status", status, {26'h0, muv, movl, diag.act_underv, diag.act_short, diag.out_ovld, diag.out_short});
      check("group_on", sf, 1'b1);
      diag = '0;
      tick(3);
      check("group_off", sf, 1'b0);
    end
    check("alarms_in", n_in, 8);
    check("alarms_out", n_out, 8);
    m.prm(8'h08, 8'h00);
    diag = '1;
    tick(3);
    diag = '0;
    tick(3);
    check("alarms_off", n_in + n_out, 16);
    // every fallback mode, reserved bits set
    lv = 8'($urandom);
    m.prm(8'h0c, lv);
    m.wr(8'h0a);
    for (int md = 0; md < 4; md++) begin
      m.prm(8'h0b, 8'hfc | 8'(md));
      bus_ok = md[0];
      dval = !md[0];
      tick(2);
      fb = (md == 0) ? 4'h0 : (md == 1) ? 4'hf : (md == 2) ? 4'ha : lv[3:0];
      check("fallback", dout, fb);
      check("bus_fault", bf, 1'b1);
      bus_ok = 1'b1;
      dval = 1'b1;
      tick(2);
      check("restored", dout, 4'ha);
    end
    // hold keeps the level applied just before the fault
    m.prm(8'h0b, 8'h02);
    m.wr(8'h06);
    tick(1);
    bus_ok = 1'b0;
    tick(2);
    check("hold_last", dout, 4'h6);
    bus_ok = 1'b1;
    m.prm(8'h0b, 8'h03);
    // kicks keep it quiet, reads do not
    m.prm(8'h08, 8'h08);
    repeat (5) begin
      tick(10);
      m.wr(8'h05);
    end
    check("wd_kicked", bf, 1'b0);
    repeat (8) m.cmd(4);
    check("wd_reads", bf, 1'b0);
    repeat (4) m.cmd(4);
    check("wd_expired", bf, 1'b1);
    check("wd_pins", dout, lv[3:0]);
    m.wr(8'h05);
    tick(1);
    check("wd_cleared", dout, 4'h5);
    m.prm(8'h08, 8'h00);
    m.cmd(3);
    m.wr(8'h03);
    tick(1);
    check("no_sync", dout, 4'h3);
    // sync holds outputs until the next one
    m.prm(8'h08, 8'h02);
    m.cmd(3);
    m.wr(8'h0c);
    tick(2);
    check("sync_hold", dout, 4'h3);
    m.cmd(3);
    tick(2);
    check("sync_next", dout, 4'hc);
    m.cmd(2);
    m.prm(8'h08, 8'h04);
    pins = 8'h5a;
    tick(2);
    m.cmd(1);
    pins = 8'ha5;
    tick(3);
    check("frozen", img_in, 8'h5a);
    m.cmd(1);
    pins = 8'h0f;
    tick(3);
    check("frozen_next", img_in, 8'ha5);
    m.cmd(0);
    tick(3);
    check("thawed", img_in, 8'h0f);
    report_and_stop();
  end
endmodule
